// file: hw/timer_pkg.sv
// Shared constants and types of the enhanced timer.
package timer_pkg;

  // ----------------------------------------------------------------
  // Widths and scaling
  // ----------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam int PER_SHIFT = 7;
  localparam logic [10:0] PER_FULL = 11'h400;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
  localparam logic [3:0] OFS_RUN_PER = 4'h2;
  localparam logic [3:0] OFS_CNT_LO = 4'h3;
  localparam logic [3:0] OFS_CNT_HI = 4'h4;
  localparam logic [3:0] OFS_CMPA_LO = 4'h5;
  localparam logic [3:0] OFS_CMPA_HI = 4'h6;
  localparam logic [3:0] OFS_CMPB_LO = 4'h7;
  localparam logic [3:0] OFS_CMPB_HI = 4'h8;
  localparam logic [3:0] OFS_FLAGS = 4'h9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_RUN = 7;
  localparam int BIT_DIR = 1;
  localparam int BIT_CLR_SEL = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [2:0] PER_RST = 3'h0;

  // ----------------------------------------------------------------
  // Pin action and alignment codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PA_KEEP = 2'h0;
  localparam logic [1:0] PA_LOW = 2'h1;
  localparam logic [1:0] PA_HIGH = 2'h2;
  localparam logic [1:0] PA_TOGGLE = 2'h3;
  localparam logic [1:0] PA_FORCE_OFF = 2'h0;
  localparam logic [1:0] PA_FORCE_ON = 2'h1;
  localparam logic [1:0] AL_EDGE = 2'h0;
  localparam logic [1:0] AL_UP = 2'h1;
  localparam logic [1:0] AL_DOWN = 2'h2;

  typedef enum logic [1:0] {MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER} mode_t;

  typedef struct packed {
    mode_t mode;
    logic [1:0] pin_act;
    logic init;
    logic invert;
  } chan_cfg_t;

  typedef struct packed {
    logic p;
    logic b;
    logic a;
  } flags_t;

endpackage

// file: hw/enhanced_timer.sv
// Enhanced timer with compare-match, timer/counter and PWM output modes.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps

module enhanced_timer (
  // Clock, reset and enable
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Output pins
  output logic OUTPUT_A_PIN_O,
  output logic OUTPUT_B_PIN_ZERO_O,
  output logic OUTPUT_B_PIN_ONE_O,
  output logic OUTPUT_B_PIN_TWO_O,
  output logic PIN_OE_N_O,
  // Match flags towards interrupt logic
  output timer_pkg::flags_t MATCH_FLAGS_O
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  timer_pkg::chan_cfg_t cfg_q [2];
  logic [9:0] cmp_q [2];
  logic clr_sel_q;
  logic [1:0] align_q;
  logic run_q;
  logic run_prev_q;
  logic [2:0] per_sel_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic dir_q;
  logic dir_d;
  timer_pkg::flags_t flags_q;
  logic [7:0] rdata_q;
  logic oe_n_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_c1 = WR_I && ADDR_I == timer_pkg::OFS_CTRL_ONE;
  wire wr_c2 = WR_I && ADDR_I == timer_pkg::OFS_CTRL_TWO;
  wire wr_rp = WR_I && ADDR_I == timer_pkg::OFS_RUN_PER;
  wire wr_al = WR_I && ADDR_I == timer_pkg::OFS_CMPA_LO;
  wire wr_ah = WR_I && ADDR_I == timer_pkg::OFS_CMPA_HI;
  wire wr_bl = WR_I && ADDR_I == timer_pkg::OFS_CMPB_LO;
  wire wr_bh = WR_I && ADDR_I == timer_pkg::OFS_CMPB_HI;
  wire wr_fl = WR_I && ADDR_I == timer_pkg::OFS_FLAGS;

  // ----------------------------------------------------------------
  // Mode and period selection
  // ----------------------------------------------------------------
  // Channel A's field stands for both channels; mixed modes are illegal.
  wire timer_pkg::mode_t mode = cfg_q[0].mode;
  wire is_cnt = mode == timer_pkg::MODE_COMPARE || mode == timer_pkg::MODE_TIMER;
  wire is_pwm = mode == timer_pkg::MODE_PWM;
  wire is_ctr = is_pwm && align_q != timer_pkg::AL_EDGE;
  wire run_rise = run_q && !run_prev_q;
  wire active = run_q && run_prev_q;
  wire per_zero = per_sel_q == 3'h0;

  // Period length in counts: compare A, or period select times 128 (1024 for select zero).
  wire [10:0] per_scaled = {8'h00, per_sel_q} << timer_pkg::PER_SHIFT;
  wire [10:0] per_n = clr_sel_q ? {1'b0, cmp_q[0]} :
                      (per_zero ? timer_pkg::PER_FULL : per_scaled);
  wire [10:0] per_m1 = per_n - 11'h001;
  wire [9:0] top = (per_n == 11'h000) ? 10'h000 : per_m1[9:0];

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  wire eq_a = cnt_q == cmp_q[0];
  wire eq_b = cnt_q == cmp_q[1];
  wire eq_p = !per_zero && cnt_q == per_scaled[9:0];
  wire ovf = cnt_q == 10'h3ff;
  wire p_cnt = !clr_sel_q && (eq_p || (per_zero && ovf));
  wire cnt_clr = clr_sel_q ? eq_a : p_cnt;
  wire at_top = cnt_q == top;
  wire at_zero = cnt_q == 10'h000;
  wire pwm_end = is_ctr ? (dir_q && at_zero) : at_top;
  wire dir_ok = !is_ctr || align_q == timer_pkg::AL_EDGE ||
                (align_q == timer_pkg::AL_UP && !dir_q) ||
                (align_q == timer_pkg::AL_DOWN && dir_q) ||
                (align_q == 2'h3);
  wire pwm_a = clr_sel_q ? pwm_end : (eq_a && dir_ok);
  wire pwm_b = eq_b && dir_ok;
  wire pwm_p = !clr_sel_q && pwm_end;

  // Match events of this cycle; P is never raised with clear select high.
  wire timer_pkg::flags_t hit = !active ? 3'h0 :
    is_cnt ? {p_cnt, eq_b, eq_a} :
    is_pwm ? {pwm_p, pwm_b, pwm_a} : 3'h0;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (run_rise) begin
      cnt_d = 10'h000;
      dir_d = 1'b0;
    end else if (run_q) begin
      if (is_pwm && is_ctr) begin
        // Count up to the top, then down to zero.
        if (top == 10'h000) begin
          cnt_d = 10'h000;
        end else if (!dir_q) begin
          cnt_d = at_top ? cnt_q - 10'h001 : cnt_q + 10'h001;
          dir_d = at_top;
        end else begin
          cnt_d = at_zero ? 10'h001 : cnt_q - 10'h001;
          dir_d = !at_zero;
        end
      end else if (is_pwm) begin
        cnt_d = at_top ? 10'h000 : cnt_q + 10'h001;
        dir_d = 1'b0;
      end else if (is_cnt) begin
        cnt_d = cnt_clr ? 10'h000 : cnt_q + 10'h001;
        dir_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 10'h001;
        dir_d = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cnt_q <= 10'h000;
      dir_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else if (CE_I) begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      run_prev_q <= run_q;
    end
  end

  // ----------------------------------------------------------------
  // Channel outputs
  // ----------------------------------------------------------------
  logic [1:0] pin_w;

  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic lvl_q;
    logic lvl_d;
    logic pin_q;
    logic pin_d;
    logic pwm_on;
    logic pwm_lvl;
    // Duty at or above the period keeps the output active.
    wire sat = {1'b0, cmp_q[i]} >= per_n;
    wire act = sat || cnt_q < cmp_q[i];
    wire unused_a = (i == 0) && clr_sel_q;
    wire ev = i == 0 ? hit.a : hit.b;

    always_comb begin
      lvl_d = lvl_q;
      if (run_rise) begin
        lvl_d = cfg_q[i].init;
      end else if (ev) begin
        // Only A and B events move the pin; P never does.
        unique case (cfg_q[i].pin_act)
          timer_pkg::PA_KEEP: lvl_d = lvl_q;
          timer_pkg::PA_LOW: lvl_d = 1'b0;
          timer_pkg::PA_HIGH: lvl_d = 1'b1;
          timer_pkg::PA_TOGGLE: lvl_d = !lvl_q;
        endcase
      end
    end

    always_comb begin
      unique case (cfg_q[i].pin_act)
        timer_pkg::PA_FORCE_OFF: pwm_on = 1'b0;
        timer_pkg::PA_FORCE_ON: pwm_on = 1'b1;
        default: pwm_on = act;
      endcase
      if (unused_a) begin
        pwm_on = 1'b0;
      end
      pwm_lvl = pwm_on ? cfg_q[i].init : !cfg_q[i].init;
    end

    always_comb begin
      if (is_pwm) begin
        pin_d = pwm_lvl ^ cfg_q[i].invert;
      end else if (mode == timer_pkg::MODE_COMPARE) begin
        pin_d = lvl_d ^ cfg_q[i].invert;
      end else begin
        pin_d = 1'b0;
      end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        lvl_q <= 1'b0;
        pin_q <= 1'b0;
      end else if (CE_I) begin
        lvl_q <= lvl_d;
        pin_q <= pin_d;
      end
    end

    assign pin_w[i] = pin_q;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg_q[0] <= timer_pkg::CTRL_RST[7:2];
      cfg_q[1] <= timer_pkg::CTRL_RST[7:2];
      clr_sel_q <= 1'b0;
      align_q <= 2'h0;
      run_q <= 1'b0;
      per_sel_q <= timer_pkg::PER_RST;
      cmp_q[0] <= timer_pkg::CMP_RST;
      cmp_q[1] <= timer_pkg::CMP_RST;
    end else if (CE_I) begin
      if (wr_c1) begin
        cfg_q[0] <= WDATA_I[7:2];
        clr_sel_q <= WDATA_I[timer_pkg::BIT_CLR_SEL];
      end
      if (wr_c2) begin
        cfg_q[1] <= WDATA_I[7:2];
        align_q <= WDATA_I[1:0];
      end
      if (wr_rp) begin
        run_q <= WDATA_I[timer_pkg::BIT_RUN];
        per_sel_q <= WDATA_I[2:0];
      end
      if (wr_al) cmp_q[0][7:0] <= WDATA_I;
      if (wr_ah) cmp_q[0][9:8] <= WDATA_I[1:0];
      if (wr_bl) cmp_q[1][7:0] <= WDATA_I;
      if (wr_bh) cmp_q[1][9:8] <= WDATA_I[1:0];
    end
  end

  // Flags clear by writing ones; a new match in the same cycle wins.
  wire timer_pkg::flags_t fl_clr = wr_fl ? WDATA_I[2:0] : 3'h0;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      flags_q <= 3'h0;
      oe_n_q <= 1'b1;
    end else if (CE_I) begin
      flags_q <= (flags_q & ~fl_clr) | hit;
      oe_n_q <= !(mode == timer_pkg::MODE_COMPARE || is_pwm);
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  wire [7:0] c1_word = {cfg_q[0], dir_q, clr_sel_q};
  wire [7:0] c2_word = {cfg_q[1], align_q};
  wire [7:0] rp_word = {run_q, 4'h0, per_sel_q};
  logic [7:0] rd_word;

  always_comb begin
    unique case (ADDR_I)
      timer_pkg::OFS_CTRL_ONE: rd_word = c1_word;
      timer_pkg::OFS_CTRL_TWO: rd_word = c2_word;
      timer_pkg::OFS_RUN_PER: rd_word = rp_word;
      timer_pkg::OFS_CNT_LO: rd_word = cnt_q[7:0];
      timer_pkg::OFS_CNT_HI: rd_word = {6'h00, cnt_q[9:8]};
      timer_pkg::OFS_CMPA_LO: rd_word = cmp_q[0][7:0];
      timer_pkg::OFS_CMPA_HI: rd_word = {6'h00, cmp_q[0][9:8]};
      timer_pkg::OFS_CMPB_LO: rd_word = cmp_q[1][7:0];
      timer_pkg::OFS_CMPB_HI: rd_word = {6'h00, cmp_q[1][9:8]};
      timer_pkg::OFS_FLAGS: rd_word = {5'h00, flags_q};
      default: rd_word = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_q <= 8'h00;
    end else if (CE_I && RD_I) begin
      rdata_q <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA_O = rdata_q;
  assign OUTPUT_A_PIN_O = pin_w[0];
  assign OUTPUT_B_PIN_ZERO_O = pin_w[1];
  assign OUTPUT_B_PIN_ONE_O = pin_w[1];
  assign OUTPUT_B_PIN_TWO_O = pin_w[1];
  assign PIN_OE_N_O = oe_n_q;
  assign MATCH_FLAGS_O = flags_q;

endmodule

// file: tb/timer_properties.sv
// Port-level properties of the enhanced timer.
`timescale 1ns/1ps
module timer_properties (
  // Clock, reset and enable
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  // Pins and flags
  input wire logic OUTPUT_A_PIN_O,
  input wire logic OUTPUT_B_PIN_ZERO_O,
  input wire logic OUTPUT_B_PIN_ONE_O,
  input wire logic OUTPUT_B_PIN_TWO_O,
  input wire logic PIN_OE_N_O,
  input wire timer_pkg::flags_t MATCH_FLAGS_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [7:0] c1_q, c2_q, bl_q;
  logic [1:0] bh_q;
  logic run_q;
  wire wr = CE_I && WR_I;
  wire rd = CE_I && RD_I;
  // Shadow copies of the fields that the properties depend on.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      bl_q <= 8'h00;
      bh_q <= 2'h0;
      run_q <= 1'b0;
    end else if (wr) begin
      if (ADDR_I == 4'h0) c1_q <= WDATA_I;
      if (ADDR_I == 4'h1) c2_q <= WDATA_I;
      if (ADDR_I == 4'h2) run_q <= WDATA_I[7];
      if (ADDR_I == 4'h7) bl_q <= WDATA_I;
      if (ADDR_I == 4'h8) bh_q <= WDATA_I[1:0];
    end
  end
  flag_a_hold_a: assert property ($past(MATCH_FLAGS_O.a) &&
    !$past(wr && ADDR_I == 4'h9 && WDATA_I[0]) |-> MATCH_FLAGS_O.a) else $error("flag a lost");
  flag_p_hold_a: assert property ($past(MATCH_FLAGS_O.p) &&
    !$past(wr && ADDR_I == 4'h9 && WDATA_I[2]) |-> MATCH_FLAGS_O.p) else $error("flag p lost");
  no_p_flag_a: assert property (c1_q[0] && $past(c1_q[0]) &&
    (c1_q[7:6] == 2'h0 || c1_q[7:6] == 2'h3) |-> !$rose(MATCH_FLAGS_O.p)) else $error("p set");
  high_zero_a: assert property (rd && (ADDR_I == 4'h6 || ADDR_I == 4'h8)
    |=> RDATA_O[7:2] == 6'h00) else $error("upper bits set");
  cmp_b_read_a: assert property (rd && ADDR_I == 4'h7 |=> RDATA_O == $past(bl_q))
    else $error("compare b low readback");
  cmp_bh_read_a: assert property (rd && ADDR_I == 4'h8 |=> RDATA_O[1:0] == $past(bh_q))
    else $error("compare b high readback");
  b_pins_same_a: assert property (OUTPUT_B_PIN_ZERO_O == OUTPUT_B_PIN_ONE_O &&
    OUTPUT_B_PIN_ONE_O == OUTPUT_B_PIN_TWO_O) else $error("b pins differ");
  timer_free_a: assert property (c1_q[7:6] == 2'h3 && $past(c1_q[7:6]) == 2'h3
    |-> PIN_OE_N_O && !OUTPUT_A_PIN_O && !OUTPUT_B_PIN_ZERO_O) else $error("pins driven");
  run_init_a: assert property ($rose(run_q) && c1_q[7:6] == 2'h0
    |-> ##[1:2] OUTPUT_A_PIN_O == (c1_q[3] ^ c1_q[2])) else $error("initial level");
  pwm_force_a: assert property (c2_q[7:5] == 3'h4 && $past(c2_q, 2) == c2_q &&
    run_q && $past(run_q, 3) |-> OUTPUT_B_PIN_ZERO_O == ((c2_q[4] ~^ c2_q[3]) ^ c2_q[2]))
    else $error("forced level");
endmodule
bind enhanced_timer timer_properties timer_properties_i (.CLK_I, .SYS_RST_I, .CE_I, .ADDR_I,
  .WDATA_I, .WR_I, .RD_I, .RDATA_O, .OUTPUT_A_PIN_O, .OUTPUT_B_PIN_ZERO_O, .OUTPUT_B_PIN_ONE_O,
  .OUTPUT_B_PIN_TWO_O, .PIN_OE_N_O, .MATCH_FLAGS_O);

// file: tb/pin_load.sv
// Load on one timer pin that counts its high cycles over a window.
`timescale 1ns/1ps
module pin_load (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic pin_i,
  input wire logic oe_n_i,
  output logic [15:0] high_cnt_o
);
  // A pin left undriven floats up through the board pull-up.
  wire level = oe_n_i ? 1'b1 : pin_i;
  always @(posedge clk_i) begin
    if (clr_i) begin
      high_cnt_o <= 16'h0000;
    end else if (level) begin
      high_cnt_o <= high_cnt_o + 16'h0001;
    end
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the enhanced timer.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr = 1'b0;
  logic [7:0] rdata;
  logic ce = 1'b1;
  logic pa, pb0, pb1, pb2, oe_n;
  timer_pkg::flags_t flags;
  logic [15:0] cnt_a, cnt_b;
  int n_errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  enhanced_timer enhanced_timer_i (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OUTPUT_A_PIN_O(pa),
    .OUTPUT_B_PIN_ZERO_O(pb0), .OUTPUT_B_PIN_ONE_O(pb1), .OUTPUT_B_PIN_TWO_O(pb2),
    .PIN_OE_N_O(oe_n), .MATCH_FLAGS_O(flags));
  pin_load pin_load_a_i (.clk_i(clk), .clr_i(clr), .pin_i(pa), .oe_n_i(oe_n),
    .high_cnt_o(cnt_a));
  pin_load pin_load_b_i (.clk_i(clk), .clr_i(clr), .pin_i(pb0), .oe_n_i(oe_n),
    .high_cnt_o(cnt_b));
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Stops the timer, clears the flags, loads both controls and starts it.
  task automatic run_cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [2:0] per);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h9, 8'h07);
    wr_reg(4'h0, c1);
    wr_reg(4'h1, c2);
    wr_reg(4'h2, {5'h10, per});
  endtask
  task automatic wait_flag(input int b, input int lim);
    int i;
    i = 0;
    while (flags[b] !== 1'b1 && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == lim) begin
      n_errors++;
      $display("wrong value at %0t: flag %0d never rose", $time, b);
    end
  endtask
  task automatic meas(input int n, input logic [15:0] ea, input logic [15:0] eb);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk(cnt_a, ea);
    chk(cnt_b, eb);
  endtask
  initial begin
    #(40 * 20000);
    n_errors = n_errors + 1;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd_reg(a[3:0], 8'h00);
    wr_reg(4'h6, 8'hff);
    rd_reg(4'h6, 8'h03);
    wr_reg(4'h8, 8'hff);
    rd_reg(4'h8, 8'h03);
    wr_reg(4'h7, 8'ha5);
    rd_reg(4'h7, 8'ha5);
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h8, 8'h00);
    wr_reg(4'h5, 8'h03);
    wr_reg(4'h7, 8'h02);
    run_cfg(8'h31, 8'h20, 3'h0);
    wait_flag(0, 20);
    chk({15'h0000, pa}, 16'h0001);
    chk({15'h0000, pb0}, 16'h0001);
    chk({13'h0000, flags}, 16'h0003);
    repeat (20) @(posedge clk);
    #1 chk({15'h0000, pa}, 16'h0000);
    // Six frozen cycles: the pin must not toggle and the counter must not move.
    @(posedge clk);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    #1 chk({15'h0000, pa}, 16'h0000);
    rd_reg(4'h3, 8'h02);
    wr_reg(4'h5, 8'hc8);
    wr_reg(4'h7, 8'hc8);
    run_cfg(8'h18, 8'h30, 3'h1);
    wait_flag(2, 300);
    chk({13'h0000, flags}, 16'h0004);
    chk({14'h0000, pa, pb0}, 16'h0002);
    wr_reg(4'h5, 8'h05);
    run_cfg(8'h18, 8'h30, 3'h1);
    wait_flag(2, 300);
    chk({13'h0000, flags}, 16'h0005);
    chk({15'h0000, pa}, 16'h0000);
    run_cfg(8'h18, 8'h30, 3'h0);
    wait_flag(2, 1100);
    chk({13'h0000, flags}, 16'h0007);
    run_cfg(8'hc0, 8'hc0, 3'h1);
    wait_flag(0, 20);
    chk({13'h0000, flags}, 16'h0001);
    chk({15'h0000, oe_n}, 16'h0001);
    wr_reg(4'h5, 8'h0a);
    wr_reg(4'h7, 8'h04);
    run_cfg(8'ha9, 8'ha8, 3'h0);
    repeat (20) @(posedge clk);
    meas(100, 16'd0, 16'd40);
    wr_reg(4'h7, 8'h14);
    repeat (20) @(posedge clk);
    meas(100, 16'd0, 16'd100);
    run_cfg(8'ha9, 8'h88, 3'h0);
    repeat (20) @(posedge clk);
    meas(100, 16'd0, 16'd0);
    run_cfg(8'ha9, 8'h98, 3'h0);
    repeat (20) @(posedge clk);
    meas(100, 16'd0, 16'd100);
    wr_reg(4'h7, 8'h04);
    run_cfg(8'ha9, 8'hac, 3'h0);
    repeat (20) @(posedge clk);
    meas(100, 16'd0, 16'd60);
    run_cfg(8'ha9, 8'ha0, 3'h0);
    repeat (20) @(posedge clk);
    meas(100, 16'd0, 16'd60);
    wr_reg(4'h5, 8'h20);
    wr_reg(4'h7, 8'h40);
    run_cfg(8'ha8, 8'ha8, 3'h1);
    repeat (140) @(posedge clk);
    meas(256, 16'd64, 16'd128);
    chk({13'h0000, flags}, 16'h0007);
    for (int al = 1; al < 4; al++) begin
      run_cfg(8'ha8, {6'h2a, al[1:0]}, 3'h1);
      wait_flag(2, 600);
    end
    finish_test();
  end
endmodule
